// [common/tmr_cfg.svh]
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
// ==========================================
// register byte offsets on the apb window
`define TMR_ADDR_W 8
`define TMR_OFF_CTRL_A 8'h00
`define TMR_OFF_CTRL_B 8'h04
`define TMR_OFF_COUNT 8'h08
`define TMR_OFF_MATCH_A 8'h0C
`define TMR_OFF_MATCH_B 8'h10
`define TMR_OFF_IRQ_MASK 8'h14
`define TMR_OFF_IRQ_FLAG 8'h18
// ==========================================
// control register a fields
`define TMR_ACT_A_HI 7
`define TMR_ACT_A_LO 6
`define TMR_ACT_B_HI 5
`define TMR_ACT_B_LO 4
`define TMR_MODE_LOW_HI 1
`define TMR_MODE_LOW_LO 0
// control register b fields
`define TMR_FORCE_A 7
`define TMR_FORCE_B 6
`define TMR_MODE_HIGH 3
`define TMR_CSEL_HI 2
`define TMR_CSEL_LO 0
// flag and mask bit positions
`define TMR_IRQ_MB 2
`define TMR_IRQ_WRAP 1
`define TMR_IRQ_MA 0
// ==========================================
// counter values and reset values
`define TMR_MAX 8'hFF
`define TMR_BOTTOM 8'h00
`define TMR_RST8 8'h00
`define TMR_RST2 2'h0
`define TMR_RST3 3'h0
`define TMR_ONE8 8'h01
// ==========================================
// waveform modes
`define TMR_MODE_NORMAL 3'h0
`define TMR_MODE_PC_FF 3'h1
`define TMR_MODE_CTC 3'h2
`define TMR_MODE_FAST_FF 3'h3
`define TMR_MODE_PC_A 3'h5
`define TMR_MODE_FAST_A 3'h7
// output action codes
`define TMR_ACT_OFF 2'h0
`define TMR_ACT_TOGGLE 2'h1
`define TMR_ACT_CLEAR 2'h2
`define TMR_ACT_SET 2'h3
// ==========================================
// clock select codes
`define TMR_CS_STOP 3'h0
`define TMR_CS_IO 3'h1
`define TMR_CS_8 3'h2
`define TMR_CS_64 3'h3
`define TMR_CS_256 3'h4
`define TMR_CS_1024 3'h5
`define TMR_CS_FALL 3'h6
`define TMR_CS_RISE 3'h7
// prescaler width and tap masks
`define TMR_PS_W 10
`define TMR_PS_RST 10'h000
`define TMR_PS_ONE 10'h001
`define TMR_TAP_8 10'h007
`define TMR_TAP_64 10'h03F
`define TMR_TAP_256 10'h0FF
`define TMR_TAP_1024 10'h3FF
`endif

// [common/tmr_pkg.sv]
// ==========================================
// shared types of the 8-bit timer
package tmr_pkg;
   // counting direction, one-hot
   typedef enum logic [1:0] {
      TMR_DIR_UP = 2'b01,
      TMR_DIR_DOWN = 2'b10
   } tmr_dir_t;
   // decoded waveform mode
   typedef struct packed {
      logic pwm;
      logic fast;
      logic phase;
      logic clear_on_match_mode;
      logic top_from_a;
   } tmr_mode_t;
   // one compare output pin: level and driver enable
   typedef struct packed {
      logic val;
      logic oe;
   } tmr_pin_t;
endpackage

// [design/tmr_timer8.sv]
`timescale 1ns/1ns
`default_nettype none
`include "tmr_cfg.svh"

// ==========================================
// 8-bit timer with two compare outputs
// Overview of operation
// RULE1 - nonzero action b routes wave to pin
// RULE2 - non-pwm: off, toggle, clear, set on match
// RULE3 - fast pwm: clear match set top, inverse
// RULE4 - match equal top ignored, top action kept
// RULE5 - phase pwm: clear up, set down, inverse
// RULE6 - mode selects sequence and top source
// RULE7 - pwm compare values load at top only
// RULE8 - wrap flag at max, bottom or top
// RULE9 - mode from ctrl a low bits plus b
// RULE10 - force bit makes immediate match non-pwm
// RULE11 - software writes force zero in pwm
// RULE12 - forced match sets no flag, no clear
// RULE13 - force bits are strobes reading zero
// RULE14 - reserved control and mask bits read zero
// RULE15 - clock select: stop, io, taps, external
// RULE16 - external edges count even if output
// RULE17 - count writable, write blocks next match
// RULE18 - both compare values compared continuously
// RULE19 - phase mode holds top one tick, reverses
// RULE20 - flags clear on service or write one
// RULE21 - counter wraps after top or match a
module tmr_timer8 (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [`TMR_ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // port logic of the two output pins, bit 1 is b, bit 0 is a
   input wire logic [1:0] port_dir_in,
   input wire logic [1:0] port_val_in,
   output tmr_pkg::tmr_pin_t wave_out_a_out,
   output tmr_pkg::tmr_pin_t wave_out_b_out,
   // external count pin and interrupt requests
   input wire logic ext_count_pin_in,
   input wire logic [2:0] irq_ack_in,
   output logic [2:0] irq_req_out
);

   // ==========================================
   // state
   logic [1:0] chan_a_output_action_q;
   logic [1:0] chan_b_output_action_q;
   logic [1:0] wave_mode_low_bits_q;
   logic wave_mode_high_bit_q;
   logic [2:0] count_clock_sel_q;
   logic [7:0] count_value_q;
   logic [7:0] match_buf_a_q;
   logic [7:0] match_buf_b_q;
   logic [7:0] match_value_a_q;
   logic [7:0] match_value_b_q;
   logic [2:0] irq_mask_q;
   logic [2:0] irq_flag_q;
   logic [`TMR_PS_W-1:0] presc_q;
   logic ext_s1_q;
   logic ext_s2_q;
   logic ext_s3_q;
   logic block_q;
   logic wave_a_q;
   logic wave_b_q;
   logic [31:0] prdata_q;
   tmr_pkg::tmr_dir_t dir_q;
   tmr_pkg::tmr_pin_t pin_a_q;
   tmr_pkg::tmr_pin_t pin_b_q;

   // ==========================================
   // combinational nets
   logic [2:0] wave_mode_sel;
   tmr_pkg::tmr_mode_t mode;
   logic setup_ph;
   logic access_ph;
   logic wr_ctrl_a, wr_ctrl_b, wr_count, wr_match_a, wr_match_b, wr_mask, wr_flag;
   logic mapped;
   logic [31:0] rd_mux;
   logic tick;
   logic [7:0] top;
   logic at_top;
   logic hit_a, hit_b;
   logic force_a, force_b;
   logic wrap_set;
   logic [2:0] flag_set;
   logic [2:0] flag_clr;
   logic [7:0] count_d;
   tmr_pkg::tmr_dir_t dir_d;

   // ==========================================
   // mode decode
   assign wave_mode_sel = {wave_mode_high_bit_q, wave_mode_low_bits_q}; // RULE9

   // reserved codes 4 and 6 run as plain up counters to 0xff
   always_comb
   begin
      mode = '0;
      case (wave_mode_sel) // RULE6
         `TMR_MODE_PC_FF:
         begin
            mode.pwm = 1'b1;
            mode.phase = 1'b1;
         end
         `TMR_MODE_CTC:
         begin
            mode.clear_on_match_mode = 1'b1;
            mode.top_from_a = 1'b1;
         end
         `TMR_MODE_FAST_FF:
         begin
            mode.pwm = 1'b1;
            mode.fast = 1'b1;
         end
         `TMR_MODE_PC_A:
         begin
            mode.pwm = 1'b1;
            mode.phase = 1'b1;
            mode.top_from_a = 1'b1;
         end
         `TMR_MODE_FAST_A:
         begin
            mode.pwm = 1'b1;
            mode.fast = 1'b1;
            mode.top_from_a = 1'b1;
         end
         default:
         begin
            mode = '0;
         end
      endcase
   end

   // ==========================================
   // apb decode, zero wait states
   assign setup_ph = psel_in && !penable_in;
   assign access_ph = psel_in && penable_in;
   assign wr_ctrl_a = access_ph && pwrite_in && (paddr_in == `TMR_OFF_CTRL_A);
   assign wr_ctrl_b = access_ph && pwrite_in && (paddr_in == `TMR_OFF_CTRL_B);
   assign wr_count = access_ph && pwrite_in && (paddr_in == `TMR_OFF_COUNT);
   assign wr_match_a = access_ph && pwrite_in && (paddr_in == `TMR_OFF_MATCH_A);
   assign wr_match_b = access_ph && pwrite_in && (paddr_in == `TMR_OFF_MATCH_B);
   assign wr_mask = access_ph && pwrite_in && (paddr_in == `TMR_OFF_IRQ_MASK);
   assign wr_flag = access_ph && pwrite_in && (paddr_in == `TMR_OFF_IRQ_FLAG);
   assign pready_out = 1'b1;
   assign pslverr_out = access_ph && !mapped;
   assign prdata_out = prdata_q;

   // read mux; force strobes and reserved bits always read zero
   always_comb
   begin
      rd_mux = '0;
      mapped = 1'b1;
      case (paddr_in)
         `TMR_OFF_CTRL_A: // RULE14
         begin
            rd_mux[`TMR_ACT_A_HI:`TMR_ACT_A_LO] = chan_a_output_action_q;
            rd_mux[`TMR_ACT_B_HI:`TMR_ACT_B_LO] = chan_b_output_action_q;
            rd_mux[`TMR_MODE_LOW_HI:`TMR_MODE_LOW_LO] = wave_mode_low_bits_q;
         end
         `TMR_OFF_CTRL_B: // RULE13
         begin
            rd_mux[`TMR_MODE_HIGH] = wave_mode_high_bit_q;
            rd_mux[`TMR_CSEL_HI:`TMR_CSEL_LO] = count_clock_sel_q;
         end
         `TMR_OFF_COUNT: rd_mux[7:0] = count_value_q; // RULE17
         `TMR_OFF_MATCH_A: rd_mux[7:0] = match_buf_a_q;
         `TMR_OFF_MATCH_B: rd_mux[7:0] = match_buf_b_q;
         `TMR_OFF_IRQ_MASK: rd_mux[2:0] = irq_mask_q;
         `TMR_OFF_IRQ_FLAG: rd_mux[2:0] = irq_flag_q;
         default: mapped = 1'b0;
      endcase
   end

   // read data is captured in the setup phase so it comes from a flop
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         prdata_q <= '0;
      else if (setup_ph && !pwrite_in)
         prdata_q <= rd_mux;
   end

   // ==========================================
   // control registers
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         chan_a_output_action_q <= `TMR_RST2;
         chan_b_output_action_q <= `TMR_RST2;
         wave_mode_low_bits_q <= `TMR_RST2;
         wave_mode_high_bit_q <= 1'b0;
         count_clock_sel_q <= `TMR_RST3;
         irq_mask_q <= `TMR_RST3;
      end
      else
      begin
         if (wr_ctrl_a)
         begin
            chan_a_output_action_q <= pwdata_in[`TMR_ACT_A_HI:`TMR_ACT_A_LO];
            chan_b_output_action_q <= pwdata_in[`TMR_ACT_B_HI:`TMR_ACT_B_LO];
            wave_mode_low_bits_q <= pwdata_in[`TMR_MODE_LOW_HI:`TMR_MODE_LOW_LO]; // RULE9
         end
         if (wr_ctrl_b)
         begin
            wave_mode_high_bit_q <= pwdata_in[`TMR_MODE_HIGH]; // RULE9
            count_clock_sel_q <= pwdata_in[`TMR_CSEL_HI:`TMR_CSEL_LO];
         end
         if (wr_mask)
            irq_mask_q <= pwdata_in[2:0];
      end
   end

   // force strobes are never stored; pwm modes ignore them, software keeps them zero there
   assign force_a = wr_ctrl_b && pwdata_in[`TMR_FORCE_A] && !mode.pwm; // RULE10 RULE11
   assign force_b = wr_ctrl_b && pwdata_in[`TMR_FORCE_B] && !mode.pwm; // RULE10 RULE11

   // ==========================================
   // clock source: free running prescaler and pin edge detector
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         presc_q <= `TMR_PS_RST;
      else
         presc_q <= presc_q + `TMR_PS_ONE;
   end

   // pin is synchronised whatever its direction, so software can drive the count
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end
      else
      begin
         ext_s1_q <= ext_count_pin_in; // RULE16
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   // timer tick select
   always_comb
   begin
      case (count_clock_sel_q) // RULE15
         `TMR_CS_STOP: tick = 1'b0;
         `TMR_CS_IO: tick = 1'b1;
         `TMR_CS_8: tick = (presc_q & `TMR_TAP_8) == `TMR_TAP_8;
         `TMR_CS_64: tick = (presc_q & `TMR_TAP_64) == `TMR_TAP_64;
         `TMR_CS_256: tick = (presc_q & `TMR_TAP_256) == `TMR_TAP_256;
         `TMR_CS_1024: tick = (presc_q & `TMR_TAP_1024) == `TMR_TAP_1024;
         `TMR_CS_FALL: tick = !ext_s2_q && ext_s3_q; // RULE16
         `TMR_CS_RISE: tick = ext_s2_q && !ext_s3_q; // RULE16
         default: tick = 1'b0;
      endcase
   end

   // ==========================================
   // compare units
   assign top = mode.top_from_a ? match_value_a_q : `TMR_MAX; // RULE6
   assign at_top = count_value_q == top;
   assign hit_a = tick && !block_q && (count_value_q == match_value_a_q); // RULE18
   assign hit_b = tick && !block_q && (count_value_q == match_value_b_q); // RULE18

   // a count write masks the match on the following tick only
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         block_q <= 1'b0;
      else if (wr_count)
         block_q <= 1'b1; // RULE17
      else if (tick)
         block_q <= 1'b0;
   end

   // written values are buffered; the compare sees them at once or at top
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         match_buf_a_q <= `TMR_RST8;
         match_buf_b_q <= `TMR_RST8;
         match_value_a_q <= `TMR_RST8;
         match_value_b_q <= `TMR_RST8;
      end
      else
      begin
         if (wr_match_a)
            match_buf_a_q <= pwdata_in[7:0];
         if (wr_match_b)
            match_buf_b_q <= pwdata_in[7:0];
         if (!mode.pwm)
         begin
            match_value_a_q <= wr_match_a ? pwdata_in[7:0] : match_buf_a_q; // RULE7
            match_value_b_q <= wr_match_b ? pwdata_in[7:0] : match_buf_b_q; // RULE7
         end
         else if (tick && at_top)
         begin
            match_value_a_q <= match_buf_a_q; // RULE7
            match_value_b_q <= match_buf_b_q; // RULE7
         end
      end
   end

   // ==========================================
   // counter sequence
   always_comb
   begin
      count_d = count_value_q;
      dir_d = dir_q;
      if (mode.phase) // RULE19
      begin
         if (dir_q == tmr_pkg::TMR_DIR_UP && count_value_q >= top)
         begin
            dir_d = tmr_pkg::TMR_DIR_DOWN;
            count_d = count_value_q - `TMR_ONE8;
         end
         else if (dir_q == tmr_pkg::TMR_DIR_DOWN && count_value_q == `TMR_BOTTOM)
         begin
            dir_d = tmr_pkg::TMR_DIR_UP;
            count_d = count_value_q + `TMR_ONE8;
         end
         else if (dir_q == tmr_pkg::TMR_DIR_UP)
            count_d = count_value_q + `TMR_ONE8;
         else
            count_d = count_value_q - `TMR_ONE8;
      end
      else
      begin
         dir_d = tmr_pkg::TMR_DIR_UP;
         if (at_top) // RULE21
            count_d = `TMR_BOTTOM;
         else
            count_d = count_value_q + `TMR_ONE8;
      end
   end

   // software writes win over a tick in the same cycle
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         count_value_q <= `TMR_RST8;
         dir_q <= tmr_pkg::TMR_DIR_UP;
      end
      else if (wr_count)
         count_value_q <= pwdata_in[7:0]; // RULE17
      else if (tick)
      begin
         count_value_q <= count_d;
         dir_q <= dir_d;
      end
   end

   // ==========================================
   // flags: hardware set beats a same-cycle clear
   always_comb
   begin
      if (mode.phase)
         wrap_set = tick && count_value_q == `TMR_BOTTOM; // RULE8
      else if (wave_mode_sel == `TMR_MODE_FAST_A)
         wrap_set = tick && at_top; // RULE8
      else
         wrap_set = tick && count_value_q == `TMR_MAX; // RULE8
   end

   assign flag_set = {hit_b, wrap_set, hit_a}; // RULE12
   assign flag_clr = irq_ack_in | (wr_flag ? pwdata_in[2:0] : 3'h0); // RULE20
   assign irq_req_out = irq_flag_q & irq_mask_q;

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         irq_flag_q <= `TMR_RST3;
      else
         irq_flag_q <= (irq_flag_q & ~flag_clr) | flag_set; // RULE20
   end

   // ==========================================
   // waveform generators
   function automatic logic wave_next(input logic cur, input logic [1:0] act, input tmr_pkg::tmr_mode_t m,
                                      input logic hit, input logic frc, input logic tick_top,
                                      input logic ocr_top, input logic up, input logic tog_ok);
      logic nxt;
      nxt = cur;
      if (!m.pwm)
      begin
         if (hit || frc) // RULE2 RULE10
         begin
            case (act)
               `TMR_ACT_TOGGLE: nxt = !cur;
               `TMR_ACT_CLEAR: nxt = 1'b0;
               `TMR_ACT_SET: nxt = 1'b1;
               default: nxt = cur;
            endcase
         end
      end
      else if (act[1])
      begin
         if (hit && !ocr_top) // RULE4
            nxt = (m.fast || up) ? act[0] : !act[0]; // RULE3 RULE5
         else if (tick_top && (m.fast || ocr_top))
            nxt = !act[0]; // RULE3 RULE4
      end
      else if (act == `TMR_ACT_TOGGLE && tog_ok && hit)
         nxt = !cur;
      return nxt;
   endfunction

   // channel a may toggle in pwm when the top comes from it; channel b never does
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wave_a_q <= 1'b0;
         wave_b_q <= 1'b0;
      end
      else
      begin
         wave_a_q <= wave_next(wave_a_q, chan_a_output_action_q, mode, hit_a, force_a, tick && at_top,
                               match_value_a_q == top, dir_q == tmr_pkg::TMR_DIR_UP, wave_mode_high_bit_q);
         wave_b_q <= wave_next(wave_b_q, chan_b_output_action_q, mode, hit_b, force_b, tick && at_top,
                               match_value_b_q == top, dir_q == tmr_pkg::TMR_DIR_UP, 1'b0);
      end
   end

   // pin mux: wave takes over while its action is nonzero, driver follows port direction
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         pin_a_q <= '0;
         pin_b_q <= '0;
      end
      else
      begin
         pin_a_q.val <= (chan_a_output_action_q != `TMR_ACT_OFF) ? wave_a_q : port_val_in[0];
         pin_a_q.oe <= port_dir_in[0];
         pin_b_q.val <= (chan_b_output_action_q != `TMR_ACT_OFF) ? wave_b_q : port_val_in[1]; // RULE1
         pin_b_q.oe <= port_dir_in[1]; // RULE1
      end
   end

   assign wave_out_a_out = pin_a_q;
   assign wave_out_b_out = pin_b_q;

   // ==========================================
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   a_pin_takes_wave: assert property ((chan_b_output_action_q != `TMR_ACT_OFF) && $stable(chan_b_output_action_q)
      |=> wave_out_b_out.val == $past(wave_b_q)) else $error("pin b does not follow wave"); // RULE1
   a_nonpwm_clear: assert property (!mode.pwm && chan_b_output_action_q == `TMR_ACT_CLEAR && hit_b
      |=> !wave_b_q) else $error("non-pwm clear failed"); // RULE2
   a_fast_top_set: assert property (mode.fast && chan_b_output_action_q == `TMR_ACT_CLEAR && tick && at_top
      && !hit_b |=> wave_b_q) else $error("fast pwm top set failed"); // RULE3
   a_top_match_ignore: assert property (mode.fast && chan_b_output_action_q == `TMR_ACT_SET && hit_b
      && match_value_b_q == top |=> !wave_b_q) else $error("match at top not ignored"); // RULE4
   a_phase_down_set: assert property (mode.phase && chan_b_output_action_q == `TMR_ACT_CLEAR && hit_b
      && dir_q == tmr_pkg::TMR_DIR_DOWN && match_value_b_q != top |=> wave_b_q) else $error("down match"); // RULE5
   a_ctc_wraps: assert property (mode.clear_on_match_mode && tick && !wr_count && count_value_q == match_value_a_q
      |=> count_value_q == `TMR_BOTTOM) else $error("ctc did not clear"); // RULE6 RULE21
   a_pwm_buffer_hold: assert property (mode.pwm && $past(mode.pwm) && !$past(tick && at_top)
      |-> $stable(match_value_b_q)) else $error("pwm compare changed off top"); // RULE7
   a_wrap_bottom: assert property (mode.phase && tick && count_value_q == `TMR_BOTTOM
      |=> irq_flag_q[`TMR_IRQ_WRAP]) else $error("wrap flag missing at bottom"); // RULE8
   a_force_no_flag: assert property ($rose(irq_flag_q[`TMR_IRQ_MB]) |-> $past(hit_b))
      else $error("flag b set without match"); // RULE12
   a_force_reads_zero: assert property (setup_ph && !pwrite_in && paddr_in == `TMR_OFF_CTRL_B
      |=> prdata_out[7:4] == 4'h0) else $error("force or reserved bits read nonzero"); // RULE13 RULE14
   a_stopped_count: assert property (count_clock_sel_q == `TMR_CS_STOP && !wr_count
      |=> $stable(count_value_q)) else $error("stopped counter moved"); // RULE15
   a_write_blocks: assert property (wr_count |=> !hit_a && !hit_b) else $error("match after count write"); // RULE17
   a_phase_turns: assert property (mode.phase && tick && !wr_count && at_top && dir_q == tmr_pkg::TMR_DIR_UP
      ##1 !wr_count |-> dir_q == tmr_pkg::TMR_DIR_DOWN && count_value_q == $past(count_value_q) - `TMR_ONE8)
      else $error("phase top not reversed"); // RULE19
   a_set_beats_clear: assert property (hit_a && flag_clr[`TMR_IRQ_MA] |=> irq_flag_q[`TMR_IRQ_MA])
      else $error("flag set lost to clear"); // RULE20

endmodule

`default_nettype wire

// [sim/tmr_pin_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// far side: count pin source and pin b tally
module tmr_pin_model (
   // clock and bench control
   input wire logic clk_in,
   input wire logic [3:0] pulses_in,
   input wire logic go_in,
   input wire logic clr_in,
   // pins
   input wire tmr_pkg::tmr_pin_t wave_b_in,
   output logic ext_pin_out,
   output logic [10:0] highs_out
);
   logic [4:0] left_q = 5'h00;
   logic [1:0] div_q = 2'h0;
   initial ext_pin_out = 1'b0;
   // four clocks per level, well inside the sampling limit
   always @(posedge clk_in)
   begin
      div_q <= div_q + 2'h1;
      if (go_in)
         left_q <= {pulses_in, 1'b0};
      else if (left_q != 5'h00 && div_q == 2'h3)
      begin
         left_q <= left_q - 5'h01;
         ext_pin_out <= ~ext_pin_out;
      end
   end
   // high cycles of pin b since the last clear
   always @(posedge clk_in)
      highs_out <= clr_in ? 11'h000 : highs_out + 11'(wave_b_in.val);
endmodule
`default_nettype wire

// [sim/timer8_waveform_control_bench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "tmr_cfg.svh"
// ==========================================
// self-checking bench of the 8-bit timer
module timer8_waveform_control_bench;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, clr = 1'b0, rerr, ext_pin, pready, pslverr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdata, r = 32'h0000_1765;
   logic [1:0] port_dir = 2'h0, port_val = 2'h0;
   logic [2:0] irq_ack = 3'h0, irq_req;
   logic [3:0] pulses = 4'h0;
   logic [10:0] highs;
   logic [32:0] q[$];
   tmr_pkg::tmr_pin_t wave_a, wave_b;
   int n_fail = 0, checks_done = 0, k;
   event rd_done;
   // 125 MHz
   always #4 clk_in = ~clk_in;
   tmr_timer8 dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .port_dir_in(port_dir), .port_val_in(port_val), .wave_out_a_out(wave_a), .wave_out_b_out(wave_b),
      .ext_count_pin_in(ext_pin), .irq_ack_in(irq_ack), .irq_req_out(irq_req));
   tmr_pin_model far (.clk_in(clk_in), .pulses_in(pulses), .go_in(go), .clr_in(clr), .wave_b_in(wave_b),
      .ext_pin_out(ext_pin), .highs_out(highs));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      begin
         t = v ^ (v << 13);
         t = t ^ (t >> 17);
         return t ^ (t << 5);
      end
   endfunction
   task automatic close_out;
      begin
         $display("checks %0d fails %0d", checks_done, n_fail);
         if (n_fail == 0 && checks_done > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task automatic judge(input logic [32:0] got, input logic [32:0] exp, input string what);
      begin
         checks_done++;
         if (got !== exp)
         begin
            n_fail++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
         end
      end
   endtask
   task automatic chk_rd(input logic [32:0] got);
      judge(got, q.pop_front(), "read");
   endtask
   task automatic chk_pin(input logic [32:0] got, input logic [32:0] exp);
      judge(got, exp, "pin");
   endtask
   task automatic note(input string s);
      $display("test %s done, %0d checks", s, checks_done);
   endtask
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      begin
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge clk_in);
         penable <= 1'b1;
         i = 0;
         do
         begin
            @(posedge clk_in);
            i++;
         end
         while (pready !== 1'b1 && i < 8);
         if (pready !== 1'b1)
         begin
            n_fail++;
            close_out();
         end
         else
         begin
            rdata = prdata;
            rerr = pslverr;
            if (!wr)
               -> rd_done;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk_in);
         end
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   // the note goes in first; addresses past the flags expect an error
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      begin
         q.push_back({a > 8'h18, e});
         apb(1'b0, a, 32'h0000_0000);
      end
   endtask
   // watcher takes the oldest note as each read lands
   always @(rd_done)
      chk_rd({rerr, rdata});
   // high cycles of pin b over whole periods after settling
   task automatic duty(input logic [7:0] ca, input logic [7:0] m, input int win, input logic [10:0] e);
      begin
         wr(`TMR_OFF_CTRL_A, {24'h00_0000, ca});
         wr(`TMR_OFF_MATCH_B, {24'h00_0000, m});
         repeat (600) @(posedge clk_in);
         clr <= 1'b1;
         @(posedge clk_in);
         clr <= 1'b0;
         repeat (win + 1) @(posedge clk_in);
         chk_pin(33'(highs), 33'(e));
      end
   endtask
   initial
   begin
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      for (k = 0; k < 8; k++)
         rd(8'(k * 4), 32'h0000_0000);
      wr(`TMR_OFF_CTRL_A, 32'hFFFF_FFFF);
      rd(`TMR_OFF_CTRL_A, 32'h0000_00F3);
      wr(`TMR_OFF_CTRL_B, 32'h0000_0038);
      rd(`TMR_OFF_CTRL_B, 32'h0000_0008);
      wr(`TMR_OFF_IRQ_MASK, 32'hFFFF_FFFF);
      rd(`TMR_OFF_IRQ_MASK, 32'h0000_0007);
      for (k = 2; k < 5; k++)
      begin
         r = xs(r);
         wr(8'(k * 4), r);
         rd(8'(k * 4), {24'h00_0000, r[7:0]});
      end
      note("regs");
      wr(`TMR_OFF_CTRL_A, 32'h0000_0000);
      wr(`TMR_OFF_CTRL_B, 32'h0000_0000);
      wr(`TMR_OFF_MATCH_A, 32'h0000_0080);
      wr(`TMR_OFF_MATCH_B, 32'h0000_0080);
      port_dir <= 2'h3;
      port_val <= 2'h2;
      repeat (3) @(posedge clk_in);
      chk_pin(33'(wave_b), 33'h0_0000_0003);
      port_val <= 2'h0;
      // forced matches: toggle, clear, set
      for (k = 1; k < 4; k++)
      begin
         wr(`TMR_OFF_CTRL_A, 32'(k * 8'h50));
         wr(`TMR_OFF_CTRL_B, 32'h0000_00C0);
         repeat (3) @(posedge clk_in);
         chk_pin(33'(wave_b.val), 33'(k != 2));
         chk_pin(33'(wave_a), 33'({k != 2, 1'b1}));
      end
      rd(`TMR_OFF_CTRL_B, 32'h0000_0000);
      rd(`TMR_OFF_IRQ_FLAG, 32'h0000_0000);
      // short run across MAX, then service acknowledge
      wr(`TMR_OFF_COUNT, 32'h0000_00FE);
      wr(`TMR_OFF_CTRL_B, 32'h0000_0001);
      wr(`TMR_OFF_CTRL_B, 32'h0000_0000);
      chk_pin(33'(irq_req), 33'h0_0000_0002);
      irq_ack <= 3'h2;
      @(posedge clk_in);
      irq_ack <= 3'h0;
      rd(`TMR_OFF_IRQ_FLAG, 32'h0000_0000);
      note("pins");
      // external edges, rising then falling
      wr(`TMR_OFF_COUNT, 32'h0000_0000);
      for (k = 0; k < 2; k++)
      begin
         wr(`TMR_OFF_CTRL_B, 32'(7 - k));
         pulses <= 4'(5 - 2 * k);
         go <= 1'b1;
         @(posedge clk_in);
         go <= 1'b0;
         repeat (60) @(posedge clk_in);
         wr(`TMR_OFF_CTRL_B, 32'h0000_0000);
         rd(`TMR_OFF_COUNT, 32'(5 + 3 * k));
      end
      note("ext");
      // clear-on-match run: 33 ticks over a period of ten
      wr(`TMR_OFF_CTRL_A, 32'h0000_0022);
      wr(`TMR_OFF_MATCH_A, 32'h0000_0009);
      wr(`TMR_OFF_MATCH_B, 32'h0000_0004);
      wr(`TMR_OFF_COUNT, 32'h0000_0000);
      wr(`TMR_OFF_CTRL_B, 32'h0000_0001);
      repeat (30) @(posedge clk_in);
      wr(`TMR_OFF_CTRL_B, 32'h0000_0000);
      rd(`TMR_OFF_COUNT, 32'h0000_0003);
      rd(`TMR_OFF_IRQ_FLAG, 32'h0000_0005);
      chk_pin(33'(wave_b.val), 33'h0_0000_0000);
      wr(`TMR_OFF_IRQ_FLAG, 32'h0000_0005);
      rd(`TMR_OFF_IRQ_FLAG, 32'h0000_0000);
      note("ctc");
      wr(`TMR_OFF_CTRL_B, 32'h0000_0001);
      duty(8'h23, 8'h40, 512, 11'h082);
      duty(8'h33, 8'h40, 512, 11'h17E);
      duty(8'h23, 8'hFF, 512, 11'h200);
      duty(8'h33, 8'hFF, 512, 11'h000);
      duty(8'h21, 8'h40, 1020, 11'h100);
      note("pwm");
      close_out();
   end
endmodule
`default_nettype wire
